// [cgid_regs.sv]
// Purpose: Cache geometry and zero block identification registers with read trap checks
// Assumes: Read requests arrive as single-cycle strobes with encoding, level and trap controls
// Notes:   Answer one cycle after the request; trap and data are mutually exclusive
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Writeback granule field reads 64 bytes
// - Reservation granule field reads 64 bytes
// - Smallest data line field reads 64 bytes
// - Instruction cache policy reads physical-physical
// - Smallest instruction line 64 bytes, others zero
// - User read traps without level one permission
// - Host kernel user read needs level two permission
// - Cache ID trap bit sends read up
// - Fine-grained read trap sends read up
// - Levels two and three always read value
// - Zero register gives zeroing block size
// - Zero register also gives tag write granule
// - Zeroing permitted bit reads zero
// - Zero block size field reads sixteen words
// - Bit 31 one, clean bit set, invalidate clear
// - Tag line field reads four, upper zero
module cgid_regs (
   // Clock and reset
   input  wire logic                     ref_clk_i,
   input  wire logic                     rst_b_i,
   // Read request
   input  wire logic                     rd_req_i,
   input  wire cgid_pkg::cgid_sysreg_t   rd_enc_i,
   input  wire cgid_pkg::cgid_level_t    current_priv_level_i,
   input  wire cgid_pkg::cgid_trap_ctl_t trap_ctl_i,
   // Read answer
   output logic                          rd_valid_o,
   output logic [63:0]                   rd_data_o,
   output logic                          trap_o,
   output logic [1:0]                    trap_level_o,
   output logic [5:0]                    trap_syndrome_o,
   output logic                          unmapped_o
);

   logic        hit_ct;
   logic        hit_zb;
   logic        host_kernel;
   logic        trap_hit;
   logic [1:0]  trap_lvl;
   logic        rom_en;
   logic        next_valid;
   logic        next_trap;
   logic [1:0]  next_trap_level;
   logic [5:0]  next_syndrome;
   logic        next_unmapped;
   logic        trap_q;
   logic [63:0] rom_data;

   // Encoding decode shared by both registers
   function automatic logic enc_match(input cgid_pkg::cgid_sysreg_t a, input cgid_pkg::cgid_sysreg_t b);
      enc_match = (a == b);
   endfunction

   assign hit_ct = rd_req_i && enc_match(rd_enc_i, cgid_pkg::CGID_ENC_CACHE_TYPE);
   assign hit_zb = rd_req_i && enc_match(rd_enc_i, cgid_pkg::CGID_ENC_ZERO_BLOCK);
   assign host_kernel = trap_ctl_i.el2_enabled && trap_ctl_i.host_kernel_mode && trap_ctl_i.hyp_general_trap;

   // Trap decision for a cache type read, first match wins
   always_comb begin
      trap_hit = 1'b0;
      trap_lvl = 2'h1;
      case (current_priv_level_i)
         cgid_pkg::CGID_LVL0: begin
            if (!host_kernel && !trap_ctl_i.user_cachetype_ok_l1) begin
               trap_hit = 1'b1;
               trap_lvl = (trap_ctl_i.el2_enabled && trap_ctl_i.hyp_general_trap) ? 2'h2 : 2'h1;
            end else if (trap_ctl_i.el2_enabled && !host_kernel && trap_ctl_i.hyp_cacheid_trap) begin
               trap_hit = 1'b1;
               trap_lvl = 2'h2;
            end else if (trap_ctl_i.el2_enabled && !host_kernel && trap_ctl_i.fine_trap_enable &&
                         trap_ctl_i.fine_read_trap_cachetype) begin
               trap_hit = 1'b1;
               trap_lvl = 2'h2;
            end else if (host_kernel && !trap_ctl_i.user_cachetype_ok_l2) begin
               trap_hit = 1'b1;
               trap_lvl = 2'h2;
            end
         end
         cgid_pkg::CGID_LVL1: begin
            if (trap_ctl_i.el2_enabled && (trap_ctl_i.hyp_cacheid_trap ||
                (trap_ctl_i.fine_trap_enable && trap_ctl_i.fine_read_trap_cachetype))) begin
               trap_hit = 1'b1;
               trap_lvl = 2'h2;
            end
         end
         default: begin
            trap_hit = 1'b0;
            trap_lvl = 2'h1;
         end
      endcase
   end

   // Answer next values; zero block read has no checks here
   always_comb begin
      next_valid      = rd_req_i;
      next_trap       = hit_ct && trap_hit;
      next_trap_level = (hit_ct && trap_hit) ? trap_lvl : 2'h0;
      next_syndrome   = (hit_ct && trap_hit) ? cgid_pkg::CGID_SYND_SYSACC : 6'h00;
      next_unmapped   = rd_req_i && !hit_ct && !hit_zb;
   end

   assign rom_en = (hit_ct && !trap_hit) || hit_zb;

   // Registered answer flags
   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rd_valid_o      <= 1'b0;
         trap_q          <= 1'b0;
         trap_level_o    <= 2'h0;
         trap_syndrome_o <= 6'h00;
         unmapped_o      <= 1'b0;
      end else begin
         rd_valid_o      <= next_valid;
         trap_q          <= next_trap;
         trap_level_o    <= next_trap_level;
         trap_syndrome_o <= next_syndrome;
         unmapped_o      <= next_unmapped;
      end
   end
   assign trap_o = trap_q;

   cgid_rom u_rom (
      .ref_clk_i (ref_clk_i),
      .rst_b_i   (rst_b_i),
      .rd_en_i   (rom_en),
      .rd_sel_i  (hit_zb),
      .rd_data_o (rom_data)
   );
   // Read data come straight from the store register; the store clears itself
   // on any cycle without an allowed read, so a trapped read never leaks the value
   assign rd_data_o = rom_data;

   // Assertions
   AST_CWG: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
      hit_ct && !trap_hit |=> rd_data_o[27:24] == 4'h4)
      else $error("Writeback granule wrong");
   AST_GEOM: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
      hit_ct && !trap_hit |=> rd_data_o[23:14] == 10'h113)
      else $error("Granule, data line or policy wrong");
   AST_IMIN: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
      hit_ct && !trap_hit |=> rd_data_o[13:0] == 14'h0004)
      else $error("Instruction line field wrong");
   AST_UPPER: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
      hit_ct && !trap_hit |=> rd_data_o[63:28] == 36'h0_0000_0049)
      else $error("Upper cache type bits wrong");
   AST_ZB: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
      hit_zb |=> rd_valid_o && !trap_o && rd_data_o == 64'h4)
      else $error("Zero block value wrong");
   AST_USR_TRAP: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
      hit_ct && current_priv_level_i == cgid_pkg::CGID_LVL0 && !host_kernel &&
      !trap_ctl_i.user_cachetype_ok_l1 |=> trap_o && trap_syndrome_o == 6'h18 && rd_data_o == 64'h0)
      else $error("User read did not trap");
   AST_HK_TRAP: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
      hit_ct && current_priv_level_i == cgid_pkg::CGID_LVL0 && host_kernel &&
      !trap_ctl_i.user_cachetype_ok_l2 |=> trap_o && trap_level_o == 2'h2)
      else $error("Host kernel user read did not trap to level two");
   AST_ID_TRAP: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
      hit_ct && current_priv_level_i == cgid_pkg::CGID_LVL1 && trap_ctl_i.el2_enabled &&
      trap_ctl_i.hyp_cacheid_trap |=> trap_o && trap_level_o == 2'h2)
      else $error("Cache ID trap missed");
   AST_FG_TRAP: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
      hit_ct && current_priv_level_i == cgid_pkg::CGID_LVL1 && trap_ctl_i.el2_enabled &&
      trap_ctl_i.fine_trap_enable && trap_ctl_i.fine_read_trap_cachetype |=> trap_o)
      else $error("Fine-grained trap missed");
   AST_HIGH: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
      hit_ct && current_priv_level_i[1] |=> rd_valid_o && !trap_o && rd_data_o[31])
      else $error("High level read trapped");

   // Level zero trap routing and answer framing
   AST_USR_L1: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
      hit_ct && current_priv_level_i == cgid_pkg::CGID_LVL0 &&
      !(trap_ctl_i.el2_enabled && trap_ctl_i.hyp_general_trap) &&
      !trap_ctl_i.user_cachetype_ok_l1 |=> trap_o && trap_level_o == 2'h1)
      else $error("User read did not trap to level one");
   AST_USR_L2: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
      hit_ct && current_priv_level_i == cgid_pkg::CGID_LVL0 && trap_ctl_i.el2_enabled &&
      trap_ctl_i.hyp_general_trap && !trap_ctl_i.host_kernel_mode &&
      !trap_ctl_i.user_cachetype_ok_l1 |=> trap_o && trap_level_o == 2'h2)
      else $error("General trap did not send user read to level two");
   AST_ID_TRAP0: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
      hit_ct && current_priv_level_i == cgid_pkg::CGID_LVL0 && trap_ctl_i.el2_enabled &&
      !trap_ctl_i.hyp_general_trap && trap_ctl_i.user_cachetype_ok_l1 &&
      trap_ctl_i.hyp_cacheid_trap |=> trap_o && trap_level_o == 2'h2)
      else $error("User cache ID trap missed");
   AST_FG_TRAP0: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
      hit_ct && current_priv_level_i == cgid_pkg::CGID_LVL0 && trap_ctl_i.el2_enabled &&
      !trap_ctl_i.hyp_general_trap && trap_ctl_i.user_cachetype_ok_l1 && trap_ctl_i.fine_trap_enable &&
      trap_ctl_i.fine_read_trap_cachetype |=> trap_o && trap_level_o == 2'h2)
      else $error("User fine-grained trap missed");
   AST_OPEN_L0: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
      hit_ct && current_priv_level_i == cgid_pkg::CGID_LVL0 && !trap_ctl_i.el2_enabled &&
      trap_ctl_i.user_cachetype_ok_l1 |=> rd_valid_o && !trap_o && rd_data_o[31])
      else $error("Permitted user read trapped");
   AST_TRAP_SYND: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
      trap_o |-> rd_valid_o && trap_level_o != 2'h0 && trap_syndrome_o == 6'h18)
      else $error("Trap answer incomplete");
   AST_UNMAPPED: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
      rd_req_i && !hit_ct && !hit_zb |=> unmapped_o && !trap_o && rd_data_o == 64'h0)
      else $error("Unknown encoding answered");
   AST_IDLE: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
      !rd_req_i |=> !rd_valid_o && rd_data_o == 64'h0)
      else $error("Answer without request");

   // Covers
   COV_CT: cover property (@(posedge ref_clk_i) disable iff (!rst_b_i) hit_ct ##1 !trap_o);
   COV_ZB: cover property (@(posedge ref_clk_i) disable iff (!rst_b_i) hit_zb);
   COV_TRAP1: cover property (@(posedge ref_clk_i) disable iff (!rst_b_i) trap_o && trap_level_o == 2'h1);
   COV_TRAP2: cover property (@(posedge ref_clk_i) disable iff (!rst_b_i) trap_o && trap_level_o == 2'h2);
   COV_UNMAP: cover property (@(posedge ref_clk_i) disable iff (!rst_b_i) unmapped_o);

endmodule
`default_nettype wire

// [cgid_pkg.sv]
// Purpose: Shared constants and types for the cache geometry identification block
// Assumes: 64-bit system register reads, encodings as used by the read instruction
// Notes:   Field values are fixed by the core configuration
package cgid_pkg;

   // Privilege levels
   typedef enum logic [1:0] {
      CGID_LVL0,
      CGID_LVL1,
      CGID_LVL2,
      CGID_LVL3
   } cgid_level_t;

   // System register encoding of a read request
   typedef struct packed {
      logic [1:0] op0;
      logic [2:0] op1;
      logic [3:0] crn;
      logic [3:0] crm;
      logic [2:0] op2;
   } cgid_sysreg_t;

   // Trap control bits sampled with a read
   typedef struct packed {
      logic el2_enabled;
      logic host_kernel_mode;
      logic hyp_general_trap;
      logic hyp_cacheid_trap;
      logic user_cachetype_ok_l1;
      logic user_cachetype_ok_l2;
      logic fine_trap_enable;
      logic fine_read_trap_cachetype;
   } cgid_trap_ctl_t;

   // Encodings of the two registers
   localparam cgid_sysreg_t CGID_ENC_CACHE_TYPE = '{2'h3, 3'h3, 4'h0, 4'h0, 3'h1};
   localparam cgid_sysreg_t CGID_ENC_ZERO_BLOCK = '{2'h3, 3'h3, 4'h0, 4'h0, 3'h7};

   // Cache type field positions
   localparam int CGID_TMIN_LSB  = 32;
   localparam int CGID_RES1_BIT  = 31;
   localparam int CGID_DIC_BIT   = 29;
   localparam int CGID_IDC_BIT   = 28;
   localparam int CGID_CWG_LSB   = 24;
   localparam int CGID_ERG_LSB   = 20;
   localparam int CGID_DMIN_LSB  = 16;
   localparam int CGID_ICACHE_INDEX_POLICY_LSB  = 14;
   localparam int CGID_IMIN_LSB  = 0;
   // Zero block field positions
   localparam int CGID_DZP_BIT   = 4;
   localparam int CGID_BS_LSB    = 0;

   // Field values
   localparam logic [5:0] CGID_TMIN_VAL = 6'h04;
   localparam logic [3:0] CGID_CWG_VAL  = 4'h4;
   localparam logic [3:0] CGID_ERG_VAL  = 4'h4;
   localparam logic [3:0] CGID_DMIN_VAL = 4'h4;
   localparam logic [1:0] CGID_ICACHE_INDEX_POLICY_VAL = 2'h3;
   localparam logic [3:0] CGID_IMIN_VAL = 4'h4;
   localparam logic       CGID_IDC_VAL  = 1'h1;
   localparam logic       CGID_DIC_VAL  = 1'h0;
   localparam logic       CGID_DZP_VAL  = 1'h0;
   localparam logic [3:0] CGID_BS_VAL   = 4'h4;
   localparam logic [3:0] CGID_BS_MAX   = 4'h9;

   // Syndrome class of a system access trap
   localparam logic [5:0] CGID_SYND_SYSACC = 6'h18;

   // Reset values of the answer
   localparam logic [63:0] CGID_DATA_RST = 64'h0;

endpackage

// [cgid_rom.sv]
// Purpose: Constant identification value store with registered read data
// Assumes: One read per cycle, select valid with the enable
// Notes:   No write path exists; the contents are fixed after reset
`timescale 1ns/1ps
`default_nettype none
module cgid_rom (
   // Clock and reset
   input  wire logic        ref_clk_i,
   input  wire logic        rst_b_i,
   // Read port
   input  wire logic        rd_en_i,
   input  wire logic        rd_sel_i,
   output var  logic [63:0] rd_data_o
);

   logic [63:0] cache_type_info;
   logic [63:0] zero_block_info;
   logic [63:0] next_rd_data;

   always_comb begin
      cache_type_info = 64'h0;
      cache_type_info[cgid_pkg::CGID_TMIN_LSB +: 6] = cgid_pkg::CGID_TMIN_VAL;
      cache_type_info[cgid_pkg::CGID_RES1_BIT]      = 1'b1;
      cache_type_info[cgid_pkg::CGID_DIC_BIT]       = cgid_pkg::CGID_DIC_VAL;
      cache_type_info[cgid_pkg::CGID_IDC_BIT]       = cgid_pkg::CGID_IDC_VAL;
      cache_type_info[cgid_pkg::CGID_CWG_LSB +: 4]  = cgid_pkg::CGID_CWG_VAL;
      cache_type_info[cgid_pkg::CGID_ERG_LSB +: 4]  = cgid_pkg::CGID_ERG_VAL;
      cache_type_info[cgid_pkg::CGID_DMIN_LSB +: 4] = cgid_pkg::CGID_DMIN_VAL;
      cache_type_info[cgid_pkg::CGID_ICACHE_INDEX_POLICY_LSB +: 2] = cgid_pkg::CGID_ICACHE_INDEX_POLICY_VAL;
      cache_type_info[cgid_pkg::CGID_IMIN_LSB +: 4] = cgid_pkg::CGID_IMIN_VAL;
   end

   // zero block value, block size also sets tag granule
   always_comb begin
      zero_block_info = 64'h0;
      zero_block_info[cgid_pkg::CGID_DZP_BIT]     = cgid_pkg::CGID_DZP_VAL;
      zero_block_info[cgid_pkg::CGID_BS_LSB +: 4] = cgid_pkg::CGID_BS_VAL;
   end

   // Read select; clears when idle so a trapped or unmapped read shows zero
   // straight from this register, with no gating after the flip-flop
   always_comb begin
      next_rd_data = cgid_pkg::CGID_DATA_RST;
      if (rd_en_i) begin
         next_rd_data = rd_sel_i ? zero_block_info : cache_type_info;
      end
   end

   // Registered read data
   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rd_data_o <= cgid_pkg::CGID_DATA_RST;
      end else begin
         rd_data_o <= next_rd_data;
      end
   end

   AST_BS_MAX: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
      rd_en_i && rd_sel_i |=> rd_data_o[3:0] <= cgid_pkg::CGID_BS_MAX)
      else $error("Zero block size above maximum");

endmodule
`default_nettype wire

// [cgid_regs_test.sv]
// Purpose: Self-checking bench for the cache geometry identification registers
// Assumes: Answer registered on the taking edge and judged at the next falling edge, inputs driven on the falling edge
// Notes:   Expected words are built from the documented field values, not from the design
`timescale 1ns/1ps
`default_nettype none
module cgid_regs_test;
   // Expected words: cache type fields packed by hand, zero block size four
   localparam logic [63:0] CT_VAL = 64'h0000_0004_9444_c004;
   localparam logic [63:0] ZB_VAL = 64'h0000_0000_0000_0004;

   // Design ports
   logic                     ref_clk_i;
   logic                     rst_b_i;
   logic                     rd_req_i;
   cgid_pkg::cgid_sysreg_t   rd_enc_i;
   cgid_pkg::cgid_level_t    current_priv_level_i;
   cgid_pkg::cgid_trap_ctl_t trap_ctl_i;
   logic                     rd_valid_o;
   logic [63:0]              rd_data_o;
   logic                     trap_o;
   logic [1:0]               trap_level_o;
   logic [5:0]               trap_syndrome_o;
   logic                     unmapped_o;
   int                       n_mismatch;
   int                       checked;

   cgid_regs u_cgid_regs (
      .ref_clk_i            (ref_clk_i),
      .rst_b_i              (rst_b_i),
      .rd_req_i             (rd_req_i),
      .rd_enc_i             (rd_enc_i),
      .current_priv_level_i (current_priv_level_i),
      .trap_ctl_i           (trap_ctl_i),
      .rd_valid_o           (rd_valid_o),
      .rd_data_o            (rd_data_o),
      .trap_o               (trap_o),
      .trap_level_o         (trap_level_o),
      .trap_syndrome_o      (trap_syndrome_o),
      .unmapped_o           (unmapped_o)
   );

   // 50 MHz clock
   always #10 ref_clk_i = ~ref_clk_i;

   // Compare helpers, one per result width
   task automatic cmp_data(input string nm, input logic [63:0] e, input logic [63:0] s);
      checked++;
      if (s !== e) begin
         n_mismatch++;
         $display("unexpected %s expected %h seen %h", nm, e, s);
      end
   endtask

   task automatic cmp_fld(input string nm, input logic [5:0] e, input logic [5:0] s);
      checked++;
      if (s !== e) begin
         n_mismatch++;
         $display("unexpected %s expected %h seen %h", nm, e, s);
      end
   endtask

   task automatic cmp_flag(input string nm, input logic e, input logic s);
      checked++;
      if (s !== e) begin
         n_mismatch++;
         $display("unexpected %s expected %b seen %b", nm, e, s);
      end
   endtask

   // One read strobe, answer judged in the next cycle, pulse end checked after
   task automatic rd(input cgid_pkg::cgid_sysreg_t e, input cgid_pkg::cgid_level_t l,
                     input logic [7:0] c, input logic [1:0] tl, input logic [63:0] d, input logic um);
      rd_req_i = 1'b1;
      rd_enc_i = e;
      current_priv_level_i = l;
      trap_ctl_i = cgid_pkg::cgid_trap_ctl_t'(c);
      @(negedge ref_clk_i);
      rd_req_i = 1'b0;
      cmp_flag("valid", 1'b1, rd_valid_o);
      cmp_flag("trap", tl != 2'h0, trap_o);
      cmp_fld("trap level", {4'h0, tl}, {4'h0, trap_level_o});
      cmp_fld("syndrome", (tl != 2'h0) ? 6'h18 : 6'h00, trap_syndrome_o);
      cmp_flag("unmapped", um, unmapped_o);
      cmp_data("data", d, rd_data_o);
      @(negedge ref_clk_i);
      cmp_flag("valid end", 1'b0, rd_valid_o);
   endtask

   // Cache type read; data only when no trap is expected
   task automatic rd_ct(input cgid_pkg::cgid_level_t l, input logic [7:0] c, input logic [1:0] tl);
      rd(cgid_pkg::CGID_ENC_CACHE_TYPE, l, c, tl, (tl == 2'h0) ? CT_VAL : 64'h0, 1'b0);
   endtask

   // Two reads on consecutive edges, the second with a different register
   task automatic back_to_back;
      rd_req_i = 1'b1;
      rd_enc_i = cgid_pkg::CGID_ENC_CACHE_TYPE;
      current_priv_level_i = cgid_pkg::CGID_LVL2;
      trap_ctl_i = cgid_pkg::cgid_trap_ctl_t'(8'h00);
      @(negedge ref_clk_i);
      rd_enc_i = cgid_pkg::CGID_ENC_ZERO_BLOCK;
      cmp_data("first data", CT_VAL, rd_data_o);
      @(negedge ref_clk_i);
      rd_req_i = 1'b0;
      cmp_flag("second valid", 1'b1, rd_valid_o);
      cmp_data("second data", ZB_VAL, rd_data_o);
      @(negedge ref_clk_i);
   endtask

   // Reset while an answer stands clears it at once
   task automatic mid_reset;
      rd_req_i = 1'b1;
      rd_enc_i = cgid_pkg::CGID_ENC_CACHE_TYPE;
      @(negedge ref_clk_i);
      rd_req_i = 1'b0;
      cmp_flag("valid before reset", 1'b1, rd_valid_o);
      rst_b_i = 1'b0;
      #1;
      cmp_flag("valid in reset", 1'b0, rd_valid_o);
      cmp_data("data in reset", 64'h0, rd_data_o);
      @(negedge ref_clk_i);
      rst_b_i = 1'b1;
      @(negedge ref_clk_i);
   endtask

   // Verdict and end of run
   task automatic stop_test;
      $display("comparisons %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // Main sequence
   initial begin
      ref_clk_i = 1'b0;
      rst_b_i = 1'b0;
      rd_req_i = 1'b0;
      rd_enc_i = cgid_pkg::CGID_ENC_CACHE_TYPE;
      current_priv_level_i = cgid_pkg::CGID_LVL0;
      trap_ctl_i = cgid_pkg::cgid_trap_ctl_t'(8'h00);
      n_mismatch = 0;
      checked = 0;
      repeat (12) @(negedge ref_clk_i);
      cmp_flag("valid in reset", 1'b0, rd_valid_o);
      rst_b_i = 1'b1;
      @(negedge ref_clk_i);
      rd_ct(cgid_pkg::CGID_LVL2, 8'hf3, 2'h0);
      rd_ct(cgid_pkg::CGID_LVL3, 8'hf3, 2'h0);
      rd_ct(cgid_pkg::CGID_LVL0, 8'h00, 2'h1);
      rd_ct(cgid_pkg::CGID_LVL0, 8'h80, 2'h1);
      rd_ct(cgid_pkg::CGID_LVL0, 8'h08, 2'h0);
      rd_ct(cgid_pkg::CGID_LVL0, 8'ha0, 2'h2);
      rd_ct(cgid_pkg::CGID_LVL0, 8'he8, 2'h2);
      rd_ct(cgid_pkg::CGID_LVL0, 8'hf7, 2'h0);
      rd_ct(cgid_pkg::CGID_LVL1, 8'h90, 2'h2);
      rd_ct(cgid_pkg::CGID_LVL0, 8'h98, 2'h2);
      rd_ct(cgid_pkg::CGID_LVL1, 8'h10, 2'h0);
      rd_ct(cgid_pkg::CGID_LVL1, 8'h83, 2'h2);
      rd_ct(cgid_pkg::CGID_LVL0, 8'h8b, 2'h2);
      rd_ct(cgid_pkg::CGID_LVL1, 8'h82, 2'h0);
      rd_ct(cgid_pkg::CGID_LVL1, 8'h81, 2'h0);
      rd(cgid_pkg::CGID_ENC_ZERO_BLOCK, cgid_pkg::CGID_LVL0, 8'h00, 2'h0, ZB_VAL, 1'b0);
      rd(cgid_pkg::CGID_ENC_ZERO_BLOCK, cgid_pkg::CGID_LVL1, 8'h93, 2'h0, ZB_VAL, 1'b0);
      rd('{2'h3, 3'h3, 4'h0, 4'h0, 3'h2}, cgid_pkg::CGID_LVL2, 8'h00, 2'h0, 64'h0, 1'b1);
      back_to_back();
      mid_reset();
      rd_ct(cgid_pkg::CGID_LVL2, 8'h00, 2'h0);
      stop_test();
   end
endmodule
`default_nettype wire
